// ---- inc/rnp_pkg.sv ----
package rnp_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_NS = 40;
    localparam int UNIT_NS = 1000;
    localparam int UNIT_CYC = (UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] UNIT_LAST = 5'(UNIT_CYC - 1);

    // Broadcast interval as a multiple of the addressed interval
    localparam logic [2:0] BCAST_MULT = 3'h5;

    // Multiframe slot structure
    localparam int SLOTS_PER_MF = 16;
    localparam int SLOT_W = 4;
    localparam int NBR_CNT_W = 4;
    localparam logic [15:0] LFSR_SEED = 16'hace1;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SLOT_MASK = 8'h04;
    localparam logic [7:0] OFS_OPP = 8'h08;
    localparam logic [7:0] OFS_T1 = 8'h0c;
    localparam logic [7:0] OFS_RATE = 8'h10;
    localparam logic [7:0] OFS_RESP = 8'h14;
    localparam logic [7:0] OFS_DED_THR = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_NBR_SEL = 8'h20;
    localparam logic [7:0] OFS_NBR_DATA = 8'h24;

    // Reset values
    localparam logic [15:0] RST_SLOT_MASK = 16'hffff;
    localparam logic [4:0] RST_OPP_M = 5'h04;
    localparam logic [3:0] RST_K = 4'h3;
    localparam logic [15:0] RST_T1 = 16'h0064;
    localparam logic [15:0] RST_RATE = 16'h0010;
    localparam logic [3:0] RST_RESP_N = 4'h1;
    localparam logic [3:0] RST_BO_MASK = 4'h7;
    localparam logic [15:0] RST_DED_THR = 16'h0100;

    typedef enum logic [1:0] {RNP_M_SYNC, RNP_M_INIT, RNP_M_IDLE, RNP_M_ACTIVE} rnp_mode_t;
    typedef enum logic [1:0] {RNP_R_FULL, RNP_R_DUTY, RNP_R_PROHIB} rnp_rate_t;
    typedef enum logic [1:0] {RNP_K_BCAST, RNP_K_RESP, RNP_K_DATA} rnp_kind_t;

    typedef struct packed {
        logic valid;
        rnp_kind_t kind;
        logic to_me;
        logic [7:0] src;
        logic [7:0] rssi;
    } rnp_rx_t;

    typedef struct packed {
        logic valid;
        rnp_kind_t kind;
        logic [7:0] dst;
        logic [NBR_CNT_W-1:0] nbr_cnt;
        logic [15:0] len;
    } rnp_tx_t;

    typedef struct packed {
        logic valid;
        logic [7:0] id;
        logic [7:0] qual;
    } rnp_nbr_t;
endpackage

// ---- logic/rnp_lfsr.sv ----
`timescale 1ns/1ps
module rnp_lfsr
    import rnp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pseudo-random value
    output logic [15:0] value
);
    // Free-running so backoff depends on arrival time as well
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value <= LFSR_SEED;
        end else begin
            value <= {value[14:0], value[15] ^ value[13] ^ value[12] ^ value[10]};
        end
    end
endmodule

// ---- logic/rnp_nbr_table.sv ----
`timescale 1ns/1ps
module rnp_nbr_table
    import rnp_pkg::*;
#(
    parameter int ENTRIES = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Update from a received probe
    input wire logic upd,
    input wire logic [7:0] upd_id,
    input wire logic [7:0] upd_rssi,
    input wire logic upd_bcast,
    input wire logic [3:0] resp_n,
    // Table state
    output rnp_nbr_t [ENTRIES-1:0] list,
    output logic [NBR_CNT_W-1:0] count,
    output logic due,
    output logic [7:0] due_id
);
    logic [ENTRIES-1:0] hit;
    logic [ENTRIES-1:0] take;
    logic [ENTRIES-1:0] fire;
    logic [ENTRIES-1:0] first_free;
    logic [3:0] bc_reg [ENTRIES];

    always_comb begin
        logic found;
        found = 1'b0;
        first_free = '0;
        count = '0;
        for (int j = 0; j < ENTRIES; j++) begin
            count = count + NBR_CNT_W'(list[j].valid);
            if (!list[j].valid && !found) begin
                first_free[j] = 1'b1;
                found = 1'b1;
            end
        end
    end

    for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
        logic [3:0] bc_inc;
        logic [9:0] wq;
        assign hit[i] = list[i].valid && list[i].id == upd_id;
        // A full table drops new neighbours rather than evicting
        assign take[i] = upd && (hit[i] || (hit == '0 && first_free[i]));
        assign bc_inc = hit[i] ? bc_reg[i] + 4'h1 : 4'h1;
        assign fire[i] = take[i] && upd_bcast && bc_inc >= resp_n;
        assign wq = ({2'h0, list[i].qual} * 10'h3) + {2'h0, upd_rssi};
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                list[i] <= '0;
                bc_reg[i] <= 4'h0;
            end else if (take[i]) begin
                list[i].valid <= 1'b1;
                list[i].id <= upd_id;
                list[i].qual <= hit[i] ? wq[9:2] : upd_rssi;
                if (upd_bcast) begin
                    bc_reg[i] <= fire[i] ? 4'h0 : bc_inc;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            due <= 1'b0;
            due_id <= 8'h00;
        end else begin
            due <= |fire;
            due_id <= upd_id;
        end
    end
endmodule

// ---- logic/rnp_top.sv ----
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module rnp_top
    import rnp_pkg::*;
#(
    parameter int NBR_ENTRIES = 8
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Channel timing
    input wire logic SYNC_LOCK,
    input wire logic SLOT_TICK,
    input wire logic [SLOT_W-1:0] SLOT_INDEX,
    // Traffic state
    input wire logic SESSION_ACTIVE,
    input wire logic [15:0] DATA_PENDING,
    input wire logic [7:0] DATA_DST,
    // Received probes
    input rnp_rx_t RX_PROBE,
    // Probe transmit
    output rnp_tx_t TX_PROBE,
    output rnp_nbr_t [NBR_ENTRIES-1:0] NBR_LIST,
    output logic USE_DEDICATED
);
    localparam int IW = $clog2(NBR_ENTRIES);

    rnp_mode_t mode_reg;
    rnp_mode_t mode_next;
    rnp_rate_t rate_reg;
    logic [SLOTS_PER_MF-1:0] slot_mask_reg;
    logic [4:0] opp_m_reg;
    logic [3:0] k_reg;
    logic [15:0] t1_reg;
    logic [15:0] modem_rate_reg;
    logic [3:0] resp_n_reg;
    logic [3:0] bo_mask_reg;
    logic [15:0] ded_thr_reg;
    logic [IW-1:0] nbr_sel_reg;
    logic [31:0] rdata_reg;

    logic [4:0] unit_cnt_reg;
    logic unit_tick;
    logic [15:0] t1_left_reg;
    logic [18:0] t2_left_reg;
    logic [18:0] t2_len;
    logic [4:0] used_reg;
    logic [4:0] used_eff;
    logic [3:0] kgap_reg;
    logic resp_pend_reg;
    logic [7:0] resp_dst_reg;
    logic [3:0] bo_reg;
    rnp_tx_t tx_reg;
    rnp_tx_t tx_next;
    rnp_nbr_t [NBR_ENTRIES-1:0] list_reg;

    rnp_nbr_t [NBR_ENTRIES-1:0] tbl_list;
    logic [NBR_CNT_W-1:0] nbr_cnt;
    logic tbl_upd;
    logic due;
    logic [7:0] due_id;
    logic [15:0] rnd;
    logic [31:0] len_prod;
    logic [15:0] max_len;
    logic use_ded;
    logic rate_ok;
    logic opp;
    logic send_resp;
    logic send_data;
    logic send_bcast;
    logic mf_start;

    // Register writes
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rate_reg <= RNP_R_FULL;
            slot_mask_reg <= RST_SLOT_MASK;
            opp_m_reg <= RST_OPP_M;
            k_reg <= RST_K;
            t1_reg <= RST_T1;
            modem_rate_reg <= RST_RATE;
            resp_n_reg <= RST_RESP_N;
            bo_mask_reg <= RST_BO_MASK;
            ded_thr_reg <= RST_DED_THR;
            nbr_sel_reg <= '0;
        end else if (REG_WR) begin
            if (REG_ADDR == OFS_CTRL) begin
                // Unused code 3 falls back to the quietest state
                if (REG_WDATA[1:0] == 2'h0) begin
                    rate_reg <= RNP_R_FULL;
                end else if (REG_WDATA[1:0] == 2'h1) begin
                    rate_reg <= RNP_R_DUTY;
                end else begin
                    rate_reg <= RNP_R_PROHIB;
                end
            end else if (REG_ADDR == OFS_SLOT_MASK) begin
                slot_mask_reg <= REG_WDATA[15:0];
            end else if (REG_ADDR == OFS_OPP) begin
                opp_m_reg <= REG_WDATA[4:0];
                k_reg <= REG_WDATA[11:8];
            end else if (REG_ADDR == OFS_T1) begin
                t1_reg <= REG_WDATA[15:0];
            end else if (REG_ADDR == OFS_RATE) begin
                modem_rate_reg <= REG_WDATA[15:0];
            end else if (REG_ADDR == OFS_RESP) begin
                resp_n_reg <= REG_WDATA[3:0];
                bo_mask_reg <= REG_WDATA[11:8];
            end else if (REG_ADDR == OFS_DED_THR) begin
                ded_thr_reg <= REG_WDATA[15:0];
            end else if (REG_ADDR == OFS_NBR_SEL) begin
                nbr_sel_reg <= REG_WDATA[IW-1:0];
            end
        end
    end

    // Register reads, data valid only in the following cycle
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_reg <= 32'h0;
        end else if (!REG_RD) begin
            rdata_reg <= 32'h0;
        end else if (REG_ADDR == OFS_CTRL) begin
            rdata_reg <= {30'h0, rate_reg};
        end else if (REG_ADDR == OFS_SLOT_MASK) begin
            rdata_reg <= {16'h0, slot_mask_reg};
        end else if (REG_ADDR == OFS_OPP) begin
            rdata_reg <= {20'h0, k_reg, 3'h0, opp_m_reg};
        end else if (REG_ADDR == OFS_T1) begin
            rdata_reg <= {16'h0, t1_reg};
        end else if (REG_ADDR == OFS_RATE) begin
            rdata_reg <= {16'h0, modem_rate_reg};
        end else if (REG_ADDR == OFS_RESP) begin
            rdata_reg <= {20'h0, bo_mask_reg, 4'h0, resp_n_reg};
        end else if (REG_ADDR == OFS_DED_THR) begin
            rdata_reg <= {16'h0, ded_thr_reg};
        end else if (REG_ADDR == OFS_STATUS) begin
            rdata_reg <= {16'h0, 3'h0, used_eff, NBR_CNT_W'(nbr_cnt), resp_pend_reg, use_ded, mode_reg};
        end else if (REG_ADDR == OFS_NBR_DATA) begin
            rdata_reg <= {15'h0, tbl_list[nbr_sel_reg]};
        end else begin
            rdata_reg <= 32'h0;
        end
    end
    assign REG_RDATA = rdata_reg;

    // Operating mode
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            RNP_M_SYNC: begin
                if (SYNC_LOCK) begin
                    mode_next = RNP_M_INIT;
                end
            end
            RNP_M_INIT: begin
                if (!SYNC_LOCK) begin
                    mode_next = RNP_M_SYNC;
                end else if (SESSION_ACTIVE) begin
                    mode_next = RNP_M_ACTIVE;
                end else if (nbr_cnt != '0) begin
                    mode_next = RNP_M_IDLE;
                end
            end
            default: begin
                if (!SYNC_LOCK) begin
                    mode_next = RNP_M_SYNC;
                end else if (SESSION_ACTIVE) begin
                    mode_next = RNP_M_ACTIVE;
                end else begin
                    mode_next = RNP_M_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_reg <= RNP_M_SYNC;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Time unit prescaler
    assign unit_tick = unit_cnt_reg == UNIT_LAST;
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            unit_cnt_reg <= 5'h0;
        end else begin
            unit_cnt_reg <= unit_tick ? 5'h0 : unit_cnt_reg + 5'h1;
        end
    end

    // Probe interval timers
    assign t2_len = 19'({3'h0, t1_reg} * BCAST_MULT);
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            t1_left_reg <= 16'h0;
            t2_left_reg <= 19'h0;
        end else begin
            if (send_data || send_resp) begin
                t1_left_reg <= t1_reg;
            end else if (unit_tick && t1_left_reg != 16'h0) begin
                t1_left_reg <= t1_left_reg - 16'h1;
            end
            if (send_data || send_resp || send_bcast) begin
                t2_left_reg <= t2_len;
            end else if (unit_tick && t2_left_reg != 19'h0) begin
                t2_left_reg <= t2_left_reg - 19'h1;
            end
        end
    end

    // Idle rate control per multiframe
    assign mf_start = SLOT_TICK && SLOT_INDEX == '0;
    assign used_eff = mf_start ? 5'h0 : used_reg;
    always_comb begin
        case (rate_reg)
            RNP_R_FULL: rate_ok = 1'b1;
            RNP_R_DUTY: rate_ok = slot_mask_reg[SLOT_INDEX] && used_eff < opp_m_reg;
            default: rate_ok = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            used_reg <= 5'h0;
            kgap_reg <= 4'h0;
        end else begin
            if (mode_reg == RNP_M_IDLE && tx_next.valid) begin
                used_reg <= used_eff + 5'h1;
                kgap_reg <= k_reg;
            end else begin
                used_reg <= used_eff;
                if (SLOT_TICK && kgap_reg != 4'h0) begin
                    kgap_reg <= kgap_reg - 4'h1;
                end
            end
        end
    end

    always_comb begin
        opp = 1'b0;
        if (SLOT_TICK) begin
            case (mode_reg)
                RNP_M_INIT: opp = 1'b1;
                RNP_M_ACTIVE: opp = 1'b1;
                RNP_M_IDLE: opp = rate_ok && kgap_reg == 4'h0;
                default: opp = 1'b0;
            endcase
        end
    end

    // Channel choice and length cap
    assign use_ded = DATA_PENDING > ded_thr_reg;
    assign USE_DEDICATED = use_ded;
    assign len_prod = 32'(t1_reg) * 32'(modem_rate_reg);
    assign max_len = len_prod > 32'h0000ffff ? 16'hffff : len_prod[15:0];

    // Transmit arbitration: response, then data, then broadcast
    assign send_resp = opp && resp_pend_reg && bo_reg == 4'h0;
    assign send_data = opp && !send_resp && mode_reg == RNP_M_ACTIVE && DATA_PENDING != 16'h0
        && !use_ded && t1_left_reg == 16'h0;
    assign send_bcast = opp && !send_resp && !send_data && t2_left_reg == 19'h0
        && (mode_reg != RNP_M_ACTIVE || DATA_PENDING == 16'h0);

    always_comb begin
        tx_next = '0;
        tx_next.nbr_cnt = nbr_cnt;
        if (send_resp) begin
            tx_next.valid = 1'b1;
            tx_next.kind = RNP_K_RESP;
            tx_next.dst = resp_dst_reg;
        end else if (send_data) begin
            tx_next.valid = 1'b1;
            tx_next.kind = RNP_K_DATA;
            tx_next.dst = DATA_DST;
            tx_next.len = DATA_PENDING > max_len ? max_len : DATA_PENDING;
        end else if (send_bcast) begin
            tx_next.valid = 1'b1;
            tx_next.kind = RNP_K_BCAST;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            tx_reg <= '0;
            list_reg <= '0;
        end else begin
            tx_reg <= tx_next;
            if (send_bcast) begin
                list_reg <= tbl_list;
            end
        end
    end
    assign TX_PROBE = tx_reg;
    assign NBR_LIST = list_reg;

    // Response scheduling; a second due response while one waits is dropped
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            resp_pend_reg <= 1'b0;
            resp_dst_reg <= 8'h00;
            bo_reg <= 4'h0;
        end else if (due && (!resp_pend_reg || send_resp)) begin
            resp_pend_reg <= 1'b1;
            resp_dst_reg <= due_id;
            bo_reg <= rnd[3:0] & bo_mask_reg;
        end else if (send_resp) begin
            resp_pend_reg <= 1'b0;
        end else if (SLOT_TICK && bo_reg != 4'h0) begin
            bo_reg <= bo_reg - 4'h1;
        end
    end

    // Received probes: responses to us and third-party data only refresh
    assign tbl_upd = RX_PROBE.valid && mode_reg != RNP_M_SYNC
        && (RX_PROBE.kind != RNP_K_RESP || RX_PROBE.to_me);

    rnp_nbr_table #(
        .ENTRIES(NBR_ENTRIES)
    ) u_table (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .upd(tbl_upd),
        .upd_id(RX_PROBE.src),
        .upd_rssi(RX_PROBE.rssi),
        .upd_bcast(RX_PROBE.kind == RNP_K_BCAST),
        .resp_n(resp_n_reg),
        .list(tbl_list),
        .count(nbr_cnt),
        .due(due),
        .due_id(due_id)
    );

    rnp_lfsr u_lfsr (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .value(rnd)
    );

    a_no_tx_unsync: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        tx_reg.valid |-> $past(mode_reg) != RNP_M_SYNC) else $error("probe sent before sync");
    a_resp_addressed: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        tx_reg.valid && tx_reg.kind == RNP_K_RESP |-> tx_reg.dst == $past(resp_dst_reg))
        else $error("response to wrong node");
    a_prohib_quiet: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        mode_reg == RNP_M_IDLE && rate_reg == RNP_R_PROHIB |=> !tx_reg.valid)
        else $error("probe in prohibited state");
    a_duty_slot_mask: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        tx_reg.valid && $past(mode_reg) == RNP_M_IDLE && $past(rate_reg) == RNP_R_DUTY
        |-> $past(slot_mask_reg[SLOT_INDEX]) && $past(used_eff) < $past(opp_m_reg))
        else $error("duty probe outside allowed slot");
    a_ratio_gap: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        tx_reg.valid && $past(mode_reg) == RNP_M_IDLE |-> kgap_reg == $past(k_reg))
        else $error("activity gap not loaded");
    a_t2_restart: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        tx_reg.valid && tx_reg.kind != RNP_K_BCAST |-> t2_left_reg == 19'($past(t1_reg) * 5))
        else $error("broadcast timer not restarted");
    a_len_cap: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        tx_reg.valid && tx_reg.kind == RNP_K_DATA |-> tx_reg.len <= $past(max_len) && !$past(use_ded))
        else $error("data packet too long");
    a_bcast_idle_data: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        tx_reg.valid && tx_reg.kind == RNP_K_BCAST && $past(mode_reg) == RNP_M_ACTIVE
        |-> $past(DATA_PENDING) == 16'h0) else $error("broadcast while data pending");
    a_data_active: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        tx_reg.valid && tx_reg.kind == RNP_K_DATA |-> $past(mode_reg) == RNP_M_ACTIVE)
        else $error("data probe outside active mode");
endmodule

// ---- tb/rnp_peer.sv ----
`timescale 1ns/1ps
module rnp_peer
    import rnp_pkg::*;
(
    // Clock
    input wire logic clk,
    // Probe link
    input rnp_tx_t tx,
    output rnp_rx_t rx,
    // Control
    input wire logic [7:0] my_id,
    input wire logic bcast_req
);
    int wait_cnt = -1;
    logic [7:0] rnd = 8'h5a;
    logic bc_pend = 1'b0;
    logic bc_seen;
    logic fire_bc;
    initial rx = '0;
    always @(posedge clk) begin
        bc_seen = tx.valid && tx.kind == RNP_K_BCAST;
        // A broadcast request waits until no response is being timed
        fire_bc = bc_pend && wait_cnt < 0 && !bc_seen;
        rnd <= {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
        bc_pend <= bcast_req || (bc_pend && !fire_bc);
        if (bc_seen) begin
            wait_cnt <= 2 + int'(rnd[2:0]);
        end else if (wait_cnt >= 0) begin
            wait_cnt <= wait_cnt - 1;
        end
        if (wait_cnt == 0 && !bc_seen) begin
            rx <= '{1'b1, RNP_K_RESP, 1'b1, my_id, 8'h80};
        end else if (fire_bc) begin
            rx <= '{1'b1, RNP_K_BCAST, 1'b0, my_id, 8'h40};
        end else begin
            // Idle src and rssi fields keep toggling; kind keeps its value
            rx <= '{1'b0, rx.kind, 1'b0, ~rx.src, ~rx.rssi};
        end
        // Data probes from the device are heard but never answered
    end
endmodule

// ---- tb/rnp_top_tb.sv ----
`timescale 1ns/1ps
module rnp_top_tb;
    import rnp_pkg::*;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, lock = 0, tick = 0, sess = 0, breq = 0, ded;
    logic [7:0] addr = 0;
    logic [7:0] dst = 8'h33;
    logic [31:0] wdata = 0, rdata, seed = 32'hb0bd, v;
    logic [3:0] idx = 0, tick_idx = 0;
    logic [15:0] pend = 0, duty_mask = 16'hffff;
    logic [2:0] allow = 0;
    rnp_rx_t rx;
    rnp_tx_t tx;
    rnp_nbr_t [7:0] nl;
    int failures = 0, checked = 0, ntx = 0, cyc = 0;
    logic [7:0] nq[$];

    rnp_top DUT (.SYS_CLK(clk), .RESETN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .SYNC_LOCK(lock), .SLOT_TICK(tick), .SLOT_INDEX(idx),
        .SESSION_ACTIVE(sess), .DATA_PENDING(pend), .DATA_DST(dst), .RX_PROBE(rx),
        .TX_PROBE(tx), .NBR_LIST(nl), .USE_DEDICATED(ded));
    rnp_peer PEER (.clk(clk), .tx(tx), .rx(rx), .my_id(8'h21), .bcast_req(breq));

    initial begin
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 d = rdata;
    endtask

    task automatic wait_tx(input int n, input int lim);
        int t0;
        t0 = ntx;
        repeat (lim) begin
            @(posedge clk);
            if (ntx >= t0 + n) break;
        end
        chk(32'(ntx >= t0 + n), 1);
    endtask

    // Slot ticks every 20 cycles, index wraps each multiframe
    always @(posedge clk) begin
        cyc <= cyc + 1;
        tick <= (cyc % 20 == 19);
        if (tick) idx <= idx + 4'h1;
    end

    // Reference model of what each transmitted probe must carry
    always @(posedge clk) begin
        if (tick) tick_idx <= idx;
        if (tx.valid) begin
            ntx++;
            chk(32'(allow[tx.kind]), 1);
            chk(32'(duty_mask[tick_idx]), 1);
            if (tx.kind == RNP_K_BCAST) chk(32'(tx.nbr_cnt), nq.size());
            if (tx.kind == RNP_K_BCAST) chk({nl[0].valid, nl[0].id}, (nq.size() > 0) ? {1'b1, nq[0]} : 9'h0);
            if (tx.kind == RNP_K_RESP) chk(32'(tx.dst), 32'h21);
            if (tx.kind == RNP_K_DATA) chk({tx.dst, tx.len}, {dst, (pend < 32) ? pend : 16'h20});
        end
        if (rx.valid && rx.kind == RNP_K_RESP && !(rx.src inside {nq})) nq.push_back(rx.src);
    end

    initial begin
        #(40 * 20000);
        failures++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1;
        rreg(OFS_T1, v);
        chk(v, 32'h64);
        rreg(8'hfc, v);
        chk(v, 0);
        repeat (300) @(posedge clk);
        chk(ntx, 0);
        wreg(OFS_T1, 32'h2);
        allow <= 3'b011;
        lock <= 1;
        wait_tx(2, 1500);
        rreg(OFS_STATUS, v);
        chk(v[1:0], 2);
        wreg(OFS_NBR_SEL, 0);
        rreg(OFS_NBR_DATA, v);
        chk(v, 32'h12180);
        breq <= 1;
        @(posedge clk);
        breq <= 0;
        wait_tx(1, 800);
        repeat (100) @(posedge clk);
        wreg(OFS_CTRL, 2);
        repeat (2) @(posedge clk);
        allow <= 0;
        v = ntx;
        repeat (800) @(posedge clk);
        chk(ntx, v);
        wreg(OFS_CTRL, 3);
        rreg(OFS_CTRL, v);
        chk(v, 2);
        wreg(OFS_SLOT_MASK, 32'h90);
        wreg(OFS_CTRL, 1);
        duty_mask <= 16'h0090;
        allow <= 3'b011;
        wait_tx(2, 3000);
        wreg(OFS_CTRL, 0);
        duty_mask <= 16'hffff;
        seed = lfsr(seed);
        pend <= 16'(seed[5:0]) + 16'h1;
        sess <= 1;
        allow <= 3'b111;
        repeat (3) @(posedge clk);
        allow <= 3'b110;
        for (int i = 0; i < 3; i++) begin
            wait_tx(1, 400);
            seed = lfsr(seed);
            if (i < 2) pend <= 16'(seed[5:0]) + 16'h1;
        end
        pend <= 16'h0101;
        @(posedge clk);
        #1 chk(32'(ded), 1);
        pend <= 16'h0100;
        @(posedge clk);
        #1 chk(32'(ded), 0);
        tally_and_finish();
    end
endmodule
